// ### verilog/stsb_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "stsb_defines.svh"
module stsb_status_bank #(
  parameter int SHORT_CYCLES = `STSB_SHORT_TIME_US * `STSB_CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // deframed serial command
  input wire logic cmd_valid,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_clear,
  input wire logic soft_rst,
  // mode and configuration
  input wire stsb_pkg::stsb_mode_type mode,
  input wire stsb_pkg::stsb_cfg_type cfg,
  input wire logic cfg_zero,
  input wire logic reset_output_released,
  input wire logic main_reg_on,
  input wire logic overvoltage_reset_option,
  // supply events
  input wire logic highside_supply_under_evt,
  input wire logic highside_supply_over_evt,
  input wire logic second_reg_overtemp_evt,
  input wire logic second_reg_under_evt,
  input wire logic main_reg_below_rst,
  input wire logic main_reg_under_evt,
  input wire logic main_reg_over_evt,
  input wire logic main_reg_under_failsafe_evt,
  // thermal events
  input wire logic thermal_shutdown_level_two,
  input wire logic thermal_shutdown_level_one,
  input wire logic thermal_prewarning_evt,
  // device events
  input wire logic illegal_sleep_evt,
  input wire logic sleep_no_wake_evt,
  input wire logic sleep_wake_pending_evt,
  input wire logic invalid_cmd_evt,
  input wire logic watchdog_failure_counter_evt,
  input wire logic wd_trig_ok,
  input wire logic wd_stopped,
  input wire logic failsafe_by_wd,
  // answers and requests
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic failsafe_req,
  output logic restart_req,
  output logic fail_output
);
  import stsb_pkg::*;

  localparam int SCW = $clog2(SHORT_CYCLES + 1);

  generate
    if (SHORT_CYCLES < 1) begin : g_bad_short
      $error("SHORT_CYCLES must be at least 1");
    end
  endgenerate

  logic [7:0] sup_reg, sup_next;
  logic [2:0] thm_reg, thm_next;
  logic [1:0] hist_reg, hist_next;
  logic inv_reg, inv_next;
  logic fail_reg, fail_next;
  logic [SCW-1:0] sc_cnt_reg, sc_cnt_next;
  logic ro_seen_reg, ro_seen_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic fs_req_reg, fs_req_next;
  logic [1:0] wd_count;
  logic wd_act;
  logic clr_sup, clr_thm, clr_dev;
  logic sleep_off;
  logic short_on;
  logic uv_allowed;
  logic hist_fail;
  logic [7:0] sup_set;
  logic [7:0] dev_view;

  stsb_wd_counter u_wd (
    .clk(clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .fail_evt(watchdog_failure_counter_evt),
    .trig_ok(wd_trig_ok),
    .wd_stopped(wd_stopped),
    .fs_due_wd(failsafe_by_wd),
    .cfg(cfg),
    .cfg_zero(cfg_zero),
    .watchdog_failure_counter(wd_count),
    .fail_act(wd_act),
    .restart(restart_req)
  );

  // command decode and event qualification
  always_comb begin
    clr_sup = cmd_valid && cmd_clear && cmd_addr == `STSB_ADDR_SUPPLY;
    clr_thm = cmd_valid && cmd_clear && cmd_addr == `STSB_ADDR_THERMAL;
    clr_dev = cmd_valid && cmd_clear && cmd_addr == `STSB_ADDR_DEVICE;
    sleep_off = (mode == stsb_sleep) && !main_reg_on;
    short_on = main_reg_on && main_reg_below_rst && sc_cnt_reg == SCW'(SHORT_CYCLES);
    uv_allowed = !sleep_off && (short_on || mode == stsb_normal || mode == stsb_stop ||
                                (mode == stsb_init && ro_seen_reg));
    sup_set = 8'h00;
    sup_set[`STSB_SUP_HS_UV] = highside_supply_under_evt;
    sup_set[`STSB_SUP_HS_OV] = highside_supply_over_evt;
    sup_set[`STSB_SUP_R2_OT] = second_reg_overtemp_evt;
    sup_set[`STSB_SUP_R2_UV] = second_reg_under_evt;
    sup_set[`STSB_SUP_SHORT] = short_on;
    sup_set[`STSB_SUP_UV_FS] = main_reg_under_failsafe_evt;
    sup_set[`STSB_SUP_UV] = main_reg_under_evt && uv_allowed;
    hist_fail = watchdog_failure_counter_evt || thermal_shutdown_level_two || main_reg_under_evt ||
                (main_reg_over_evt && overvoltage_reset_option) ||
                illegal_sleep_evt || sleep_no_wake_evt;
    dev_view = {hist_reg, 2'h0, wd_count, inv_reg, fail_reg};
  end

  // short timer, counts only while the regulator is on and low
  always_comb begin
    sc_cnt_next = sc_cnt_reg;
    if (!main_reg_on || !main_reg_below_rst) begin
      sc_cnt_next = '0;
    end else if (sc_cnt_reg != SCW'(SHORT_CYCLES)) begin
      sc_cnt_next = sc_cnt_reg + SCW'(1);
    end
    // release is remembered so init mode may update the flag later
    ro_seen_next = ro_seen_reg || reset_output_released;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_cnt_reg <= '0;
      ro_seen_reg <= 1'b0;
    end else begin
      sc_cnt_reg <= sc_cnt_next;
      ro_seen_reg <= ro_seen_next;
    end
  end

  // status registers: set terms are applied after the clear
  always_comb begin
    sup_next = (clr_sup ? 8'h00 : sup_reg) | sup_set;
    thm_next = (clr_thm ? `STSB_THM_RST_VAL : thm_reg) |
               {thermal_shutdown_level_two, thermal_shutdown_level_one, thermal_prewarning_evt};
    hist_next = clr_dev ? `STSB_HIST_NONE : hist_reg;
    if (hist_fail) begin
      hist_next = `STSB_HIST_FAIL;
    end else if (sleep_wake_pending_evt) begin
      hist_next = `STSB_HIST_SLEEP;
    end
    inv_next = (inv_reg && !clr_dev) || invalid_cmd_evt;
    fail_next = (fail_reg && !clr_dev) || wd_act;
    fs_req_next = thermal_shutdown_level_two;
    if (soft_rst) begin
      sup_next = `STSB_SUP_SOFT_VAL;
      thm_next = `STSB_THM_RST_VAL;
      hist_next = `STSB_HIST_NONE;
      inv_next = 1'b0;
      fail_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup_reg <= `STSB_SUP_POR_VAL;
      thm_reg <= `STSB_THM_RST_VAL;
      hist_reg <= `STSB_HIST_NONE;
      inv_reg <= 1'b0;
      fail_reg <= 1'b0;
      fs_req_reg <= 1'b0;
    end else begin
      sup_reg <= sup_next;
      thm_reg <= thm_next;
      hist_reg <= hist_next;
      inv_reg <= inv_next;
      fail_reg <= fail_next;
      fs_req_reg <= fs_req_next;
    end
  end

  // read path: a clear command also returns the value before clearing
  always_comb begin
    rd_valid_next = cmd_valid;
    rd_data_next = rd_data_reg;
    if (cmd_valid) begin
      unique case (cmd_addr)
        `STSB_ADDR_SUPPLY: rd_data_next = sup_reg;
        `STSB_ADDR_THERMAL: rd_data_next = {5'h00, thm_reg};
        `STSB_ADDR_DEVICE: rd_data_next = dev_view;
        default: rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign failsafe_req = fs_req_reg;
  assign fail_output = wd_act;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_soft_zero;
    soft_rst |=> sup_reg == 8'h00 && thm_reg == 3'h0 && hist_reg == 2'h0;
  endproperty
  a_soft_zero: assert property (p_soft_zero) else $error("soft reset left status");
  property p_hs_latch;
    highside_supply_under_evt && !soft_rst |=> sup_reg[6] [*2] or (sup_reg[6] ##1 $past(clr_sup || soft_rst));
  endproperty
  a_hs_latch: assert property (p_hs_latch) else $error("highside under not latched");
  property p_short_cause;
    $rose(sup_reg[2]) |-> $past(main_reg_on && main_reg_below_rst && sc_cnt_reg == SCW'(SHORT_CYCLES));
  endproperty
  a_short_cause: assert property (p_short_cause) else $error("short flag without cause");
  property p_uv4;
    main_reg_under_failsafe_evt && !soft_rst |=> sup_reg[1];
  endproperty
  a_uv4: assert property (p_uv4) else $error("fail-safe undervoltage flag missing");
  property p_uv_mode;
    $rose(sup_reg[0]) |-> $past(mode != stsb_restart || short_on);
  endproperty
  a_uv_mode: assert property (p_uv_mode) else $error("undervoltage set in restart");
  property p_sleep_off;
    $rose(sup_reg[2] || sup_reg[0]) |-> !$past(sleep_off);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("flag set with regulator off");
  sequence s_thermal_shutdown_level_two_seen;
    thermal_shutdown_level_two && !soft_rst;
  endsequence
  property p_thermal_shutdown_level_two;
    s_thermal_shutdown_level_two_seen |=> thm_reg[2] && failsafe_req && hist_reg == 2'h1;
  endproperty
  a_thermal_shutdown_level_two: assert property (p_thermal_shutdown_level_two) else $error("second level shutdown not handled");
  property p_thm_hold;
    !clr_thm && !soft_rst |=> (thm_reg & $past(thm_reg)) == $past(thm_reg);
  endproperty
  a_thm_hold: assert property (p_thm_hold) else $error("thermal flag lost");
  sequence s_read_thm;
    cmd_valid && cmd_addr == `STSB_ADDR_THERMAL;
  endsequence
  property p_thm_reserved;
    s_read_thm |=> rd_valid && rd_data[7:3] == 5'h00;
  endproperty
  a_thm_reserved: assert property (p_thm_reserved) else $error("reserved thermal bits set");
  property p_read_sup;
    cmd_valid && !cmd_clear && cmd_addr == `STSB_ADDR_SUPPLY && !soft_rst
      |=> rd_valid && rd_data == $past(sup_reg) && (sup_reg & rd_data) == rd_data;
  endproperty
  a_read_sup: assert property (p_read_sup) else $error("read changed or misreported");
  property p_clr_dev;
    clr_dev && !hist_fail && !sleep_wake_pending_evt && !invalid_cmd_evt && !wd_act && !soft_rst
      |=> hist_reg == 2'h0 && !inv_reg && !fail_reg;
  endproperty
  a_clr_dev: assert property (p_clr_dev) else $error("device clear failed");
  property p_set_wins;
    clr_dev && invalid_cmd_evt && !soft_rst |=> inv_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
  property p_fail_flag;
    wd_act && !soft_rst |=> fail_reg;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("failure flag missing");
endmodule // stsb_status_bank
`default_nettype wire

// ### verilog/stsb_defines.svh
`ifndef STSB_DEFINES_SVH
`define STSB_DEFINES_SVH
// register addresses (7-bit serial address)
`define STSB_ADDR_SUPPLY 7'h41
`define STSB_ADDR_THERMAL 7'h42
`define STSB_ADDR_DEVICE 7'h43
// supply register bits
`define STSB_SUP_POR 7
`define STSB_SUP_HS_UV 6
`define STSB_SUP_HS_OV 5
`define STSB_SUP_R2_OT 4
`define STSB_SUP_R2_UV 3
`define STSB_SUP_SHORT 2
`define STSB_SUP_UV_FS 1
`define STSB_SUP_UV 0
// thermal register bits
`define STSB_THM_THERMAL_SHUTDOWN_LEVEL_TWO 2
`define STSB_THM_THERMAL_SHUTDOWN_LEVEL_ONE 1
`define STSB_THM_TPW 0
// device register bits
`define STSB_DEV_HIST_HI 7
`define STSB_DEV_HIST_LO 6
`define STSB_DEV_WD_HI 3
`define STSB_DEV_WD_LO 2
`define STSB_DEV_INVALID 1
`define STSB_DEV_FAILURE 0
// reset values
`define STSB_SUP_POR_VAL 8'h80
`define STSB_SUP_SOFT_VAL 8'h00
`define STSB_THM_RST_VAL 3'h0
`define STSB_HIST_NONE 2'h0
`define STSB_HIST_FAIL 2'h1
`define STSB_HIST_SLEEP 2'h2
// watchdog failure counts at fail-output activation
`define STSB_WD_LIMIT_ONE 2'h1
`define STSB_WD_LIMIT_TWO 2'h2
// timing
`define STSB_SHORT_TIME_US 4000
`define STSB_CLK_MHZ 50
`endif

// ### verilog/stsb_pkg.sv
`default_nettype none
package stsb_pkg;
  typedef enum logic [2:0] {
    stsb_init, stsb_normal, stsb_stop, stsb_sleep, stsb_restart, stsb_failsafe
  } stsb_mode_type;
  typedef enum logic [1:0] {stsb_cfg1, stsb_cfg2, stsb_cfg3, stsb_cfg4} stsb_cfg_type;
endpackage
`default_nettype wire

// ### verilog/stsb_wd_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "stsb_defines.svh"
module stsb_wd_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  // watchdog events
  input wire logic fail_evt,
  input wire logic trig_ok,
  input wire logic wd_stopped,
  input wire logic fs_due_wd,
  // configuration
  input wire stsb_pkg::stsb_cfg_type cfg,
  input wire logic cfg_zero,
  // results
  output logic [1:0] watchdog_failure_counter,
  output logic fail_act,
  output logic restart
);
  import stsb_pkg::*;
  logic [1:0] cnt_reg, cnt_next;
  logic frozen_reg, frozen_next;
  logic act_reg, act_next;
  logic rst_reg, rst_next;
  logic [1:0] limit;
  logic [1:0] inc;

  always_comb begin
    limit = (cfg == stsb_cfg2) ? `STSB_WD_LIMIT_ONE : `STSB_WD_LIMIT_TWO;
    inc = cnt_reg + 2'h1;
    cnt_next = cnt_reg;
    frozen_next = frozen_reg;
    act_next = 1'b0;
    rst_next = 1'b0;
    if (trig_ok) begin
      cnt_next = 2'h0;
      frozen_next = 1'b0;
    end else if (wd_stopped && !fs_due_wd) begin
      cnt_next = 2'h0;
    end
    if (fail_evt) begin
      rst_next = 1'b1;
      // counter frozen in config 2 and 4
      if (!frozen_reg) begin
        cnt_next = (cnt_reg >= limit) ? limit : inc;
        if (cnt_next == limit) begin
          act_next = !(cfg_zero && cnt_next == 2'h1);
          frozen_next = (cfg == stsb_cfg2) || (cfg == stsb_cfg4);
        end
      end
    end
    if (soft_rst) begin
      cnt_next = 2'h0;
      frozen_next = 1'b0;
      act_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
      frozen_reg <= 1'b0;
      act_reg <= 1'b0;
      rst_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      frozen_reg <= frozen_next;
      act_reg <= act_next;
      rst_reg <= rst_next;
    end
  end

  assign watchdog_failure_counter = cnt_reg;
  assign fail_act = act_reg;
  assign restart = rst_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_wd_never_three;
    cnt_reg != 2'h3;
  endproperty
  a_wd_never_three: assert property (p_wd_never_three) else $error("wd counter reached 3");
  property p_wd_trig_clears;
    trig_ok && !fail_evt |=> cnt_reg == 2'h0 && !frozen_reg;
  endproperty
  a_wd_trig_clears: assert property (p_wd_trig_clears) else $error("wd counter not cleared");
  // a second failure right behind the first may legally activate, so it is left out
  property p_wd_cfg_zero;
    fail_evt && cfg_zero && !frozen_reg && cnt_reg == 2'h0 && !soft_rst ##1 !fail_evt
      |-> !act_reg ##1 !act_reg;
  endproperty
  a_wd_cfg_zero: assert property (p_wd_cfg_zero) else $error("fail output on first failure");
endmodule // stsb_wd_counter
`default_nettype wire

// ### sim/stsb_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module stsb_mcu_model (
  // clock
  input wire logic clk,
  // command side
  output logic cmd_valid,
  output logic [6:0] cmd_addr,
  output logic cmd_clear,
  output logic soft_rst,
  // answer side
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd_addr = 7'h00;
    cmd_clear = 1'b0;
    soft_rst = 1'b0;
  end

  task automatic xfer(input logic [6:0] addr, input logic clr, output logic [7:0] data, output logic ok);
    int i;
    ok = 1'b0;
    data = 8'h00;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_addr <= addr;
    cmd_clear <= clr;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // released lines carry the inverse so a stale address is never mistaken for a live one
    cmd_addr <= ~addr;
    cmd_clear <= ~clr;
    // answer is taken at the edge that samples rd_valid high, so the caller resumes on an edge
    for (i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end
    end
  endtask

  task automatic soft_reset();
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
  endtask
endmodule // stsb_mcu_model
`default_nettype wire

// ### sim/stsb_status_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "stsb_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module stsb_status_bank_tb;
  import stsb_pkg::*;
  localparam int SHORT = 8;
  localparam logic [6:0] SUP = `STSB_ADDR_SUPPLY;
  localparam logic [6:0] THM = `STSB_ADDR_THERMAL;
  localparam logic [6:0] DEV = `STSB_ADDR_DEVICE;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] ev = 16'h0000;
  logic below = 1'b0, on = 1'b0, rro = 1'b0, ovr = 1'b0, wd_stop = 1'b0, fs_wd = 1'b0, cz = 1'b0;
  stsb_mode_type mode = stsb_init;
  stsb_cfg_type cfg = stsb_cfg1;
  logic cmd_valid, cmd_clear, soft_rst, rd_valid, fs_req, rs_req, fo;
  logic [6:0] cmd_addr;
  logic [7:0] rd_data;
  int n_fail = 0;
  int total_checks = 0;
  int i;
  logic [3:0] hidx [4] = '{4'd10, 4'd11, 4'd6, 4'd12};
  logic [1:0] hexp [4] = '{2'h1, 2'h1, 2'h1, 2'h2};
  logic [2:0] sbit [5] = '{3'd6, 3'd5, 3'd4, 3'd3, 3'd1};

  always #10 clk = ~clk;

  stsb_status_bank #(.SHORT_CYCLES(SHORT)) DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_clear(cmd_clear), .soft_rst(soft_rst), .mode(mode), .cfg(cfg),
    .cfg_zero(cz), .reset_output_released(rro), .main_reg_on(on), .overvoltage_reset_option(ovr),
    .highside_supply_under_evt(ev[0]), .highside_supply_over_evt(ev[1]), .second_reg_overtemp_evt(ev[2]),
    .second_reg_under_evt(ev[3]), .main_reg_below_rst(below), .main_reg_under_evt(ev[5]),
    .main_reg_over_evt(ev[6]), .main_reg_under_failsafe_evt(ev[4]), .thermal_shutdown_level_two(ev[7]),
    .thermal_shutdown_level_one(ev[8]), .thermal_prewarning_evt(ev[9]), .illegal_sleep_evt(ev[10]),
    .sleep_no_wake_evt(ev[11]), .sleep_wake_pending_evt(ev[12]), .invalid_cmd_evt(ev[13]),
    .watchdog_failure_counter_evt(ev[14]), .wd_trig_ok(ev[15]), .wd_stopped(wd_stop), .failsafe_by_wd(fs_wd),
    .rd_data(rd_data), .rd_valid(rd_valid), .failsafe_req(fs_req), .restart_req(rs_req),
    .fail_output(fo));

  stsb_mcu_model mcu (.clk(clk), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_clear(cmd_clear),
    .soft_rst(soft_rst), .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    mcu.xfer(a, c, d, ok);
    if (!ok) begin
      n_fail++;
      $display("FAIL answer timeout exp 1 got 0");
      end_of_test();
    end else begin
      `CHK("register", e, d)
    end
  endtask

  task automatic uv(input stsb_mode_type m, input logic o, input logic [7:0] e);
    @(posedge clk);
    mode <= m;
    on <= o;
    pulse(5);
    rd(SUP, 1'b1, e);
  endtask

  task automatic wdf(input logic er, input logic ef);
    pulse(14);
    #1;
    `CHK("restart_req", er, rs_req)
    `CHK("fail_output", ef, fo)
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(SUP, 1'b0, 8'h80);
    rd(SUP, 1'b0, 8'h80);
    rd(THM, 1'b0, 8'h00);
    rd(DEV, 1'b0, 8'h00);
    rd(7'h44, 1'b0, 8'h00);
    rd(SUP, 1'b1, 8'h80);
    rd(SUP, 1'b0, 8'h00);
    $display("test reset_and_access done");
    for (i = 0; i < 5; i++) begin
      pulse(i);
      rd(SUP, 1'b1, 8'h01 << sbit[i]);
    end
    uv(stsb_init, 1'b1, 8'h00);
    uv(stsb_restart, 1'b1, 8'h00);
    uv(stsb_sleep, 1'b0, 8'h00);
    @(posedge clk);
    rro <= 1'b1;
    @(posedge clk);
    rro <= 1'b0;
    uv(stsb_init, 1'b1, 8'h01);
    uv(stsb_normal, 1'b1, 8'h01);
    uv(stsb_stop, 1'b1, 8'h01);
    @(posedge clk);
    below <= 1'b1;
    repeat (SHORT) @(posedge clk);
    below <= 1'b0;
    rd(SUP, 1'b0, 8'h00);
    below <= 1'b1;
    repeat (SHORT + 1) @(posedge clk);
    below <= 1'b0;
    rd(SUP, 1'b1, 8'h04);
    mode <= stsb_sleep;
    on <= 1'b0;
    below <= 1'b1;
    repeat (SHORT + 4) @(posedge clk);
    below <= 1'b0;
    pulse(5);
    rd(SUP, 1'b0, 8'h00);
    $display("test supply done");
    pulse(7);
    #1;
    `CHK("failsafe_req", 1'b1, fs_req)
    pulse(8);
    pulse(9);
    rd(THM, 1'b0, 8'h07);
    rd(THM, 1'b1, 8'h07);
    rd(THM, 1'b0, 8'h00);
    rd(DEV, 1'b1, 8'h40);
    $display("test thermal done");
    ovr <= 1'b1;
    for (i = 0; i < 4; i++) begin
      pulse(hidx[i]);
      rd(DEV, 1'b1, {hexp[i], 6'h00});
    end
    ovr <= 1'b0;
    pulse(6);
    rd(DEV, 1'b0, 8'h00);
    fork
      rd(DEV, 1'b1, 8'h00);
      pulse(13);
    join
    rd(DEV, 1'b0, 8'h02);
    rd(DEV, 1'b1, 8'h02);
    rd(DEV, 1'b0, 8'h00);
    $display("test device_flags done");
    cfg <= stsb_cfg2;
    wdf(1'b1, 1'b1);
    rd(DEV, 1'b0, 8'h45);
    wdf(1'b1, 1'b0);
    rd(DEV, 1'b1, 8'h45);
    rd(DEV, 1'b0, 8'h04);
    pulse(15);
    rd(DEV, 1'b0, 8'h00);
    cfg <= stsb_cfg1;
    wdf(1'b1, 1'b0);
    rd(DEV, 1'b0, 8'h44);
    wdf(1'b1, 1'b1);
    wdf(1'b1, 1'b1);
    rd(DEV, 1'b1, 8'h49);
    wd_stop <= 1'b1;
    fs_wd <= 1'b1;
    repeat (2) @(posedge clk);
    rd(DEV, 1'b0, 8'h08);
    fs_wd <= 1'b0;
    repeat (2) @(posedge clk);
    wd_stop <= 1'b0;
    rd(DEV, 1'b0, 8'h00);
    cfg <= stsb_cfg2;
    cz <= 1'b1;
    wdf(1'b1, 1'b0);
    rd(DEV, 1'b1, 8'h44);
    pulse(15);
    cz <= 1'b0;
    cfg <= stsb_cfg4;
    wdf(1'b1, 1'b0);
    wdf(1'b1, 1'b1);
    wdf(1'b1, 1'b0);
    rd(DEV, 1'b1, 8'h49);
    $display("test watchdog done");
    pulse(0);
    pulse(8);
    mcu.soft_reset();
    rd(SUP, 1'b0, 8'h00);
    rd(THM, 1'b0, 8'h00);
    rd(DEV, 1'b0, 8'h00);
    $display("test soft_reset done");
    end_of_test();
  end
endmodule // stsb_status_bank_tb
`default_nettype wire
